// ==== rtl/xds_pkg.sv ====
// Purpose: Shared constants and types for the data memory steering block
// Assumes: 8-bit core, 40 MHz clock, SFR-style register port from the core
// Notes on behaviour
// - 1024 bytes of expanded RAM sit at external data addresses 000h to 3FFh.
// - Lower internal RAM 00h-7Fh is reachable directly and indirectly.
// - Upper internal RAM 80h-FFh is reachable only by indirect or stack accesses.
// - Direct access above 7Fh hits special registers; indirect hits upper RAM.
// - Expanded RAM occupies the lowest external data addresses.
// - Bypass clear: register or pointer moves hit expanded RAM, pins stay idle.
// - Bypass clear: pointer moves above exposed size go out on the external bus.
// - Expanded RAM above 0FFh reachable only by pointer moves; register moves are 8-bit.
// - Bypass set: register move puts 8-bit address on port 0, muxed with data.
// - Bypass set: pointer move puts high byte on port 2, low byte on port 0.
// - External moves pulse write strobe for stores, read strobe for loads.
// - Size field at bits 3:2 hides part of expanded RAM; default code 00.
// - Stack accesses stay in 256 bytes of internal RAM, never expanded RAM.
// - Stretch bit lengthens strobes from 6 to 30 clocks; default 6.
// - Bypass bit at position 1 loads from security byte after power-up.
// - Reserved control bits read as zero; software must not write ones.
// - Reset clears stretch, size and latch-quiet bits; bypass from security byte.

package xds_pkg;

  localparam logic [7:0]  AUX_MEMORY_CONTROL_ADDR = 8'h8E;
  localparam int          STRETCH_BIT             = 5;
  localparam int          SIZE_HI_BIT             = 3;
  localparam int          SIZE_LO_BIT             = 2;
  localparam int          BYPASS_BIT              = 1;
  localparam int          QUIET_BIT               = 0;
  localparam logic [7:0]  AUX_WRITE_MASK          = 8'h2F;
  localparam logic [7:0]  LOWER_RAM_TOP           = 8'h7F;
  localparam logic [15:0] EXPANDED_RAM_TOP                = 16'h03FF;
  localparam int          EXPANDED_RAM_BYTES              = 1024;
  localparam logic [9:0]  SIZE_UNIT               = 10'h100;

  localparam int          CLK_MHZ                 = 40;
  localparam int          STROBE_SHORT_CLK        = 6;
  localparam int          STROBE_LONG_CLK         = 30;
  localparam int          ADDR_PHASE_CLK          = 2;
  localparam int          HOLD_PHASE_CLK          = 1;
  localparam int          ALE_PERIOD_CLK          = 6;
  localparam logic [4:0]  STROBE_SHORT            = 5'(STROBE_SHORT_CLK);
  localparam logic [4:0]  STROBE_LONG             = 5'(STROBE_LONG_CLK);
  localparam logic [4:0]  ADDR_PHASE              = 5'(ADDR_PHASE_CLK);
  localparam logic [4:0]  HOLD_PHASE              = 5'(HOLD_PHASE_CLK);
  localparam logic [2:0]  ALE_PERIOD              = 3'(ALE_PERIOD_CLK);

  typedef enum logic [1:0] {
    XDS_MODE_DIRECT,
    XDS_MODE_INDIRECT,
    XDS_MODE_STACK
  } xds_mode_t;

  typedef struct packed {
    logic       valid;
    xds_mode_t  mode;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xds_int_req_t;

  typedef struct packed {
    logic        valid;
    logic        use_pointer;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xds_ext_req_t;

  typedef struct packed {
    logic       lower_ram;
    logic       upper_ram;
    logic       sfr;
  } xds_int_sel_t;

endpackage : xds_pkg

// ==== rtl/xds_ram.sv ====
// Purpose: Byte-wide flip-flop storage for expanded RAM
// Assumes: One access per cycle, synchronous read
// Notes: Read data is registered
`timescale 1ns/1ps
`default_nettype none
module xds_ram (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       we,
  input  wire logic       re,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] rdata_q
);

  logic [7:0] mem_q [xds_pkg::EXPANDED_RAM_BYTES];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (re) begin
      rdata_q <= mem_q[addr];
    end
  end

endmodule : xds_ram
`default_nettype wire

// ==== rtl/xds_steer.sv ====
// Purpose: Data memory steering: internal RAM decode, expanded RAM, external bus
// Assumes: Core issues one request at a time and waits for done
// Notes: Port 0 is a two-way pin split into in, out and enable (low drives)
`timescale 1ns/1ps
`default_nettype none
module xds_steer (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Special register port from core
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic [7:0]           sfr_wdata,
  output var  logic [7:0]           sfr_rdata_q,
  output var  logic                 sfr_hit_q,
  // Security byte, stable after power-up
  input  wire logic                 security_config_byte_ram,
  // Internal RAM path
  input  wire xds_pkg::xds_int_req_t int_req,
  output var  logic [7:0]           int_rdata_q,
  output var  xds_pkg::xds_int_sel_t int_sel_q,
  // External move path
  input  wire xds_pkg::xds_ext_req_t ext_req,
  input  wire logic                 code_fetch,
  output var  logic                 ext_done_q,
  output var  logic [7:0]           ext_rdata_q,
  // Pins
  input  wire logic [7:0]           p0_in,
  output var  logic [7:0]           p0_out_q,
  output var  logic [7:0]           p0_oe_n_q,
  output var  logic [7:0]           p2_out_q,
  output var  logic                 p2_addr_drive_q,
  output var  logic                 rd_n_q,
  output var  logic                 wr_n_q,
  output var  logic                 ale_q
);

  typedef enum logic [2:0] {
    XDS_IDLE,
    XDS_EXPANDED_RAM,
    XDS_ADDR,
    XDS_STROBE,
    XDS_HOLD
  } xds_state_t;

  // Exposed expanded RAM size in bytes for a size code
  function automatic logic [10:0] xds_exposed(input logic [1:0] code);
    xds_exposed = 11'({1'b0, code} + 3'h1) * 11'(xds_pkg::SIZE_UNIT);
  endfunction : xds_exposed

  logic [7:0]  aux_q;
  logic        strap_done_q;
  xds_state_t  state_q;
  logic [4:0]  cnt_q;
  logic        ext_write_q;
  logic [2:0]  ale_cnt_q;
  logic [7:0]  p0_in_s1_q;
  logic [7:0]  p0_in_s2_q;
  logic [7:0]  lower_q [128];
  logic [7:0]  upper_q [128];
  logic [7:0]  expanded_ram_rdata;
  logic        expanded_ram_hit;
  logic [10:0] exposed;
  logic        expanded_ram_we;
  logic        expanded_ram_re;
  logic [4:0]  strobe_len;

  // Size check: register moves carry 8 bits, so they never pass 0FFh
  assign exposed    = xds_exposed({aux_q[xds_pkg::SIZE_HI_BIT], aux_q[xds_pkg::SIZE_LO_BIT]});
  assign expanded_ram_hit   = !aux_q[xds_pkg::BYPASS_BIT]
                      && (ext_req.addr < {5'h00, exposed})
                      && (ext_req.addr <= xds_pkg::EXPANDED_RAM_TOP)
                      && (ext_req.use_pointer || ext_req.addr[15:8] == 8'h00);
  assign expanded_ram_we    = (state_q == XDS_IDLE) && ext_req.valid && expanded_ram_hit && ext_req.write;
  assign expanded_ram_re    = (state_q == XDS_IDLE) && ext_req.valid && expanded_ram_hit && !ext_req.write;
  assign strobe_len = aux_q[xds_pkg::STRETCH_BIT] ? xds_pkg::STROBE_LONG : xds_pkg::STROBE_SHORT;

  xds_ram u_ram (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (expanded_ram_we),
    .re      (expanded_ram_re),
    .addr    (ext_req.addr[9:0]),
    .wdata   (ext_req.wdata),
    .rdata_q (expanded_ram_rdata)
  );

  // Control register, bypass bit strapped once after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_q        <= 8'h00;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      aux_q[xds_pkg::BYPASS_BIT] <= security_config_byte_ram;
      strap_done_q               <= 1'b1;
    end else if (sfr_wr && sfr_addr == xds_pkg::AUX_MEMORY_CONTROL_ADDR) begin
      aux_q <= sfr_wdata & xds_pkg::AUX_WRITE_MASK;
    end
  end

  // Register read-back; reserved bits read as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end else begin
      sfr_hit_q   <= sfr_rd && sfr_addr == xds_pkg::AUX_MEMORY_CONTROL_ADDR;
      sfr_rdata_q <= (sfr_rd && sfr_addr == xds_pkg::AUX_MEMORY_CONTROL_ADDR) ? aux_q : 8'h00;
    end
  end

  // Internal RAM: lower by any mode, upper by indirect or stack only
  always_ff @(posedge clk) begin
    if (int_req.valid && int_req.write) begin
      if (int_req.addr <= xds_pkg::LOWER_RAM_TOP) begin
        lower_q[int_req.addr[6:0]] <= int_req.wdata;
      end else if (int_req.mode != xds_pkg::XDS_MODE_DIRECT) begin
        upper_q[int_req.addr[6:0]] <= int_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_rdata_q <= 8'h00;
      int_sel_q   <= '0;
    end else begin
      int_sel_q <= '0;
      if (int_req.valid) begin
        if (int_req.addr <= xds_pkg::LOWER_RAM_TOP) begin
          int_sel_q.lower_ram <= 1'b1;
          int_rdata_q         <= lower_q[int_req.addr[6:0]];
        end else if (int_req.mode == xds_pkg::XDS_MODE_DIRECT) begin
          int_sel_q.sfr <= 1'b1;
          int_rdata_q   <= 8'h00;
        end else begin
          int_sel_q.upper_ram <= 1'b1;
          int_rdata_q         <= upper_q[int_req.addr[6:0]];
        end
      end
    end
  end

  // Input synchroniser for port 0 read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_in_s1_q <= 8'h00;
      p0_in_s2_q <= 8'h00;
    end else begin
      p0_in_s1_q <= p0_in;
      p0_in_s2_q <= p0_in_s1_q;
    end
  end

  // External move sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q         <= XDS_IDLE;
      cnt_q           <= 5'h00;
      ext_write_q     <= 1'b0;
      ext_done_q      <= 1'b0;
      ext_rdata_q     <= 8'h00;
      p0_out_q        <= 8'hFF;
      p0_oe_n_q       <= 8'hFF;
      p2_out_q        <= 8'hFF;
      p2_addr_drive_q <= 1'b0;
      rd_n_q          <= 1'b1;
      wr_n_q          <= 1'b1;
    end else begin
      ext_done_q <= 1'b0;
      unique case (state_q)
        XDS_IDLE: begin
          if (ext_req.valid) begin
            ext_write_q <= ext_req.write;
            if (expanded_ram_hit) begin
              state_q <= XDS_EXPANDED_RAM;
            end else begin
              p0_out_q  <= ext_req.addr[7:0];
              p0_oe_n_q <= 8'h00;
              if (ext_req.use_pointer) begin
                p2_out_q        <= ext_req.addr[15:8];
                p2_addr_drive_q <= 1'b1;
              end
              cnt_q   <= xds_pkg::ADDR_PHASE;
              state_q <= XDS_ADDR;
            end
          end
        end
        XDS_EXPANDED_RAM: begin
          ext_rdata_q <= expanded_ram_rdata;
          ext_done_q  <= 1'b1;
          state_q     <= XDS_IDLE;
        end
        XDS_ADDR: begin
          if (cnt_q == 5'h01) begin
            if (ext_write_q) begin
              p0_out_q <= ext_req.wdata;
              wr_n_q   <= 1'b0;
            end else begin
              p0_oe_n_q <= 8'hFF;
              rd_n_q    <= 1'b0;
            end
            cnt_q   <= strobe_len;
            state_q <= XDS_STROBE;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        XDS_STROBE: begin
          if (cnt_q == 5'h01) begin
            if (!ext_write_q) begin
              ext_rdata_q <= p0_in_s2_q;
            end
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            cnt_q   <= xds_pkg::HOLD_PHASE;
            state_q <= XDS_HOLD;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        XDS_HOLD: begin
          p0_oe_n_q       <= 8'hFF;
          p0_out_q        <= 8'hFF;
          p2_addr_drive_q <= 1'b0;
          ext_done_q      <= 1'b1;
          state_q         <= XDS_IDLE;
        end
        default: begin
          state_q <= XDS_IDLE;
        end
      endcase
    end
  end

  // Address latch strobe: free-running unless quiet bit set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ale_cnt_q <= 3'h0;
      ale_q     <= 1'b0;
    end else begin
      ale_cnt_q <= (ale_cnt_q == xds_pkg::ALE_PERIOD - 3'h1) ? 3'h0 : ale_cnt_q + 3'h1;
      if (aux_q[xds_pkg::QUIET_BIT]) begin
        ale_q <= (state_q == XDS_IDLE && ext_req.valid && !expanded_ram_hit) || code_fetch;
      end else begin
        ale_q <= (ale_cnt_q == 3'h0);
      end
    end
  end

endmodule : xds_steer
`default_nettype wire

// ==== test/xds_ext_mem.sv ====
// Purpose: External memory on the multiplexed port 0 / port 2 bus
// Assumes: Address sits on port 0 in the cycle its driver turns on
// Notes: Released bus shows a pattern that flips every cycle
`timescale 1ns/1ps
`default_nettype none
module xds_ext_mem (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] p0_out_q,
  input  wire logic [7:0] p0_oe_n_q,
  input  wire logic [7:0] p2_out_q,
  input  wire logic       p2_addr_drive_q,
  input  wire logic       rd_n_q,
  input  wire logic       wr_n_q,
  output var  logic [7:0] p0_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  logic [7:0]  idle_q;
  logic        oe_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_q <= 8'h5A;
      oe_q   <= 1'b0;
    end else begin
      idle_q <= ~idle_q;
      oe_q   <= !p0_oe_n_q[0];
      if (!p0_oe_n_q[0] && !oe_q)
        addr_q <= {p2_addr_drive_q ? p2_out_q : 8'h00, p0_out_q};
      if (!wr_n_q)
        mem[addr_q] <= p0_out_q;
    end
  end
  // Wire level from both drivers
  always_comb begin
    for (int i = 0; i < 8; i++)
      p0_in[i] = !p0_oe_n_q[i] ? p0_out_q[i] : (!rd_n_q ? mem[addr_q][i] : idle_q[i]);
  end
endmodule : xds_ext_mem
`default_nettype wire

// ==== test/xds_steer_checker.sv ====
// Purpose: Port checker for xds_steer
// Assumes: One clock domain
// Notes: Stretch bit shadowed from register writes
`timescale 1ns/1ps
`default_nettype none
module xds_steer_checker (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  sfr_wr,
  input wire logic                  sfr_rd,
  input wire logic [7:0]            sfr_addr,
  input wire logic [7:0]            sfr_wdata,
  input wire logic [7:0]            sfr_rdata_q,
  input wire logic                  sfr_hit_q,
  input wire xds_pkg::xds_int_req_t int_req,
  input wire xds_pkg::xds_int_sel_t int_sel_q,
  input wire xds_pkg::xds_ext_req_t ext_req,
  input wire logic [7:0]            p0_out_q,
  input wire logic [7:0]            p0_oe_n_q,
  input wire logic [7:0]            p2_out_q,
  input wire logic                  p2_addr_drive_q,
  input wire logic                  rd_n_q,
  input wire logic                  wr_n_q
);
  logic       str_q;
  logic [5:0] cnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      str_q <= 1'b0;
    else if (sfr_wr && sfr_addr == 8'h8E)
      str_q <= sfr_wdata[5];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cnt_q <= 6'h00;
    else if (!rd_n_q || !wr_n_q)
      cnt_q <= cnt_q + 6'h01;
    else
      cnt_q <= 6'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_addr_out;
    $fell(p0_oe_n_q[0]) && ext_req.valid;
  endsequence
  sequence s_strobe_end;
    $rose(rd_n_q && wr_n_q);
  endsequence
  property p_lower;
    int_req.valid && int_req.addr <= 8'h7F |=> int_sel_q.lower_ram && !int_sel_q.sfr;
  endproperty
  a_lower: assert property (p_lower) else $error("lower ram not selected");
  property p_upper;
    int_req.valid && int_req.mode != xds_pkg::XDS_MODE_DIRECT && int_req.addr > 8'h7F
      |=> int_sel_q.upper_ram && !int_sel_q.sfr;
  endproperty
  a_upper: assert property (p_upper) else $error("upper ram not selected");
  property p_sfr;
    int_req.valid && int_req.mode == xds_pkg::XDS_MODE_DIRECT && int_req.addr > 8'h7F
      |=> int_sel_q.sfr && !int_sel_q.upper_ram;
  endproperty
  a_sfr: assert property (p_sfr) else $error("register space not selected");
  property p_hit;
    sfr_rd && sfr_addr == 8'h8E |=> sfr_hit_q && sfr_rdata_q[5] == str_q;
  endproperty
  a_hit: assert property (p_hit) else $error("control read wrong");
  property p_rsvd;
    sfr_hit_q |-> (sfr_rdata_q & 8'hD0) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_strobe;
    s_strobe_end |-> cnt_q == (str_q ? 6'h1E : 6'h06);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe length wrong");
  property p_rdwr;
    !rd_n_q || !wr_n_q |-> ext_req.valid && rd_n_q != wr_n_q && wr_n_q != ext_req.write;
  endproperty
  a_rdwr: assert property (p_rdwr) else $error("strobe kind wrong");
  property p_addr;
    s_addr_out |-> p0_out_q == ext_req.addr[7:0] && p2_addr_drive_q == ext_req.use_pointer
      && (!ext_req.use_pointer || p2_out_q == ext_req.addr[15:8]);
  endproperty
  a_addr: assert property (p_addr) else $error("address phase wrong");
endmodule : xds_steer_checker
bind xds_steer xds_steer_checker xds_steer_checker_inst (.clk, .reset_n, .sfr_wr, .sfr_rd, .sfr_addr,
  .sfr_wdata, .sfr_rdata_q, .sfr_hit_q, .int_req, .int_sel_q, .ext_req, .p0_out_q, .p0_oe_n_q, .p2_out_q,
  .p2_addr_drive_q, .rd_n_q, .wr_n_q);
`default_nettype wire

// ==== test/xds_steer_tb.sv ====
// Purpose: Self-checking bench for xds_steer
// Assumes: Strap selects expanded RAM until the second reset, which sets it to select bypass
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module xds_steer_tb;
  logic                  clk, reset_n, sfr_wr, sfr_rd, security_config_byte_ram, code_fetch;
  logic                  sfr_hit_q, ext_done_q, p2_addr_drive_q, rd_n_q, wr_n_q, ale_q;
  logic [7:0]            sfr_addr, sfr_wdata, sfr_rdata_q, int_rdata_q, ext_rdata_q;
  logic [7:0]            p0_in, p0_out_q, p0_oe_n_q, p2_out_q;
  xds_pkg::xds_int_req_t int_req;
  xds_pkg::xds_int_sel_t int_sel_q;
  xds_pkg::xds_ext_req_t ext_req;
  int                    miscompares, cmp_count, n;
  xds_steer xds_steer_inst (.clk, .reset_n, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata_q, .sfr_hit_q,
    .security_config_byte_ram, .int_req, .int_rdata_q, .int_sel_q, .ext_req, .code_fetch, .ext_done_q,
    .ext_rdata_q, .p0_in, .p0_out_q, .p0_oe_n_q, .p2_out_q, .p2_addr_drive_q, .rd_n_q, .wr_n_q, .ale_q);
  xds_ext_mem xds_ext_mem_inst (.clk, .reset_n, .p0_out_q, .p0_oe_n_q, .p2_out_q, .p2_addr_drive_q,
    .rd_n_q, .wr_n_q, .p0_in);
  task automatic results;
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge clk);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    if (!w) begin
      chk("hit", {7'h00, a == 8'h8E}, {7'h00, sfr_hit_q});
      chk("reg", e, sfr_rdata_q);
    end
  endtask : reg_acc
  task automatic int_acc(input xds_pkg::xds_mode_t m, input logic w, input logic [7:0] a, input logic [7:0] d,
                         input logic [2:0] s, input logic [7:0] e);
    @(negedge clk);
    int_req = '{1'b1, m, w, a, d};
    @(negedge clk);
    int_req.valid = 1'b0;
    chk("sel", {5'h00, s}, {5'h00, int_sel_q});
    if (!w)
      chk("int", e, int_rdata_q);
  endtask : int_acc
  // Outcome: bus used or not, strobe low cycles, load data
  task automatic ext_acc(input logic p, input logic w, input logic [15:0] a, input logic [7:0] d,
                         input logic x, input int l, input logic [7:0] e);
    int   k;
    int   lo;
    logic pins;
    @(negedge clk);
    ext_req = '{1'b1, p, w, a, d};
    k = 0;
    lo = 0;
    pins = 1'b0;
    while (ext_done_q !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
      lo += (rd_n_q && wr_n_q) ? 0 : 1;
      pins |= p0_oe_n_q !== 8'hFF || (rd_n_q && wr_n_q) !== 1'b1;
    end
    ext_req.valid = 1'b0;
    if (k >= 60) begin
      miscompares++;
      results();
    end
    chk("ext", {7'h00, x}, {7'h00, pins});
    chk("len", 8'(l), 8'(lo));
    if (!w)
      chk("load", e, ext_rdata_q);
  endtask : ext_acc
  task automatic ale_win(input logic e);
    n = 0;
    repeat (24) begin
      @(negedge clk);
      n += (ale_q === 1'b1) ? 1 : 0;
    end
    chk("ale", {7'h00, e}, {7'h00, n != 0});
  endtask : ale_win
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {reset_n, sfr_wr, sfr_rd, security_config_byte_ram, code_fetch} = '0;
    {sfr_addr, sfr_wdata} = '0;
    int_req = '0;
    ext_req = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    reg_acc(0, 8'h8E, 8'h00, 8'h00);
    reg_acc(0, 8'h8F, 8'h00, 8'h00);
    int_acc(xds_pkg::XDS_MODE_INDIRECT, 1, 8'h10, 8'hA1, 3'h4, 8'h00);
    int_acc(xds_pkg::XDS_MODE_DIRECT, 0, 8'h10, 8'h00, 3'h4, 8'hA1);
    int_acc(xds_pkg::XDS_MODE_INDIRECT, 1, 8'h90, 8'hB2, 3'h2, 8'h00);
    int_acc(xds_pkg::XDS_MODE_DIRECT, 1, 8'h90, 8'hC3, 3'h1, 8'h00);
    int_acc(xds_pkg::XDS_MODE_DIRECT, 0, 8'h90, 8'h00, 3'h1, 8'h00);
    int_acc(xds_pkg::XDS_MODE_STACK, 0, 8'h90, 8'h00, 3'h2, 8'hB2);
    ext_acc(1, 1, 16'h00FF, 8'h5A, 0, 0, 8'h00);
    ext_acc(0, 0, 16'h00FF, 8'h00, 0, 0, 8'h5A);
    for (int c = 0; c < 4; c++) begin
      reg_acc(1, 8'h8E, 8'(c << 2), 8'h00);
      ext_acc(1, 1, 16'(c * 256 + 255), 8'(c), 0, 0, 8'h00);
      ext_acc(1, 1, 16'(c * 256 + 256), 8'(c + 16), 1, 6, 8'h00);
      ext_acc(1, 0, 16'(c * 256 + 256), 8'h00, 1, 6, 8'(c + 16));
    end
    reg_acc(1, 8'h8E, 8'h02, 8'h00);
    ext_acc(0, 1, 16'h00FF, 8'h77, 1, 6, 8'h00);
    ext_acc(0, 0, 16'h00FF, 8'h00, 1, 6, 8'h77);
    ext_acc(1, 1, 16'h1234, 8'hC3, 1, 6, 8'h00);
    reg_acc(1, 8'h8E, 8'h22, 8'h00);
    ext_acc(1, 0, 16'h1234, 8'h00, 1, 30, 8'hC3);
    ale_win(1);
    reg_acc(1, 8'h8E, 8'h23, 8'h00);
    ale_win(0);
    code_fetch = 1'b1;
    ale_win(1);
    code_fetch = 1'b0;
    reg_acc(0, 8'h8E, 8'h00, 8'h23);
    // Second reset with the strap set: bypass must come up set
    @(negedge clk);
    reset_n = 1'b0;
    security_config_byte_ram = 1'b1;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    reg_acc(0, 8'h8E, 8'h00, 8'h02);
    ext_acc(1, 0, 16'h00FF, 8'h00, 1, 6, 8'h77);
    results();
  end
endmodule : xds_steer_tb
`default_nettype wire
